// ### core/fsp_pkg.sv
package fsp_pkg;
	localparam int unsigned FSP_ADDR_W      = 14;
	localparam int unsigned FSP_PAGE_W      = 6;
	localparam int unsigned FSP_STALLING_REGION_START  = 14'h3000;
	// boot size fuse selects 256/512/1024/2048 words of boot section
	localparam int unsigned FSP_BOOT_BASE_W = 8;
	localparam logic [31:0] FSP_CTRL_ADDR   = 32'h0000_0000;
	localparam logic [31:0] FSP_STAT_ADDR   = 32'h0000_0004;
	localparam logic [31:0] FSP_LOCK_ADDR   = 32'h0000_0008;
	localparam logic [31:0] FSP_FUSE_ADDR   = 32'h0000_000C;
	localparam int unsigned FSP_BUSY_BIT    = 6;
	localparam int unsigned FSP_REEN_BIT    = 4;
	localparam int unsigned FSP_WRT_BIT     = 2;
	localparam int unsigned FSP_ERS_BIT     = 1;
	localparam int unsigned FSP_LOAD_BIT    = 0;
	localparam logic [3:0]  FSP_LOCK_RST    = 4'hF;
	localparam logic [1:0]  FSP_FUSE_RST    = 2'h0;
	localparam int unsigned FSP_PROG_NS     = 4000;
	localparam int unsigned FSP_CLK_MHZ     = 50;
	localparam int unsigned FSP_PROG_CYC    =
		(FSP_PROG_NS * FSP_CLK_MHZ + 999) / 1000;
	typedef struct packed {
		logic                  valid;
		logic [FSP_ADDR_W-1:0] pc;
		logic [FSP_ADDR_W-1:0] zptr;
		logic                  erase;
		logic                  write;
		logic                  load;
	} fsp_store_s;
	typedef struct packed {
		logic                  valid;
		logic [FSP_ADDR_W-1:0] addr;
	} fsp_fetch_s;
	typedef enum logic [1:0] {
		FSP_IDLE,
		FSP_RUN_CONC,
		FSP_RUN_STALL
	} fsp_state_e;
endpackage : fsp_pkg

// ### core/fsp_section_map.sv
`timescale 1ns/1ns
module fsp_section_map
	import fsp_pkg::*;
(
	input  wire logic [FSP_ADDR_W-1:0] addr,        // flash word address
	input  wire logic [1:0]            boot_size,   // boot size fuses
	output logic                       in_boot,     // in boot loader section
	output logic                       in_stall     // in stalling region
);
	logic [FSP_ADDR_W-1:0] boot_len;
	logic [FSP_ADDR_W-1:0] boot_start;
	always_comb begin
		boot_len   = FSP_ADDR_W'(1) << (FSP_BOOT_BASE_W + 32'(boot_size));
		boot_start = FSP_ADDR_W'(0) - boot_len;
		in_boot    = (addr >= boot_start);
		in_stall   = (addr >= FSP_ADDR_W'(FSP_STALLING_REGION_START));
	end
endmodule : fsp_section_map

// ### core/fsp_ctrl.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// - store instruction fetched from application section is ignored
// - programming starts only when store runs from boot loader section
// - boot loader store may target any page, boot section included
// - pointer region at issue selects concurrent read or stall
// - concurrent-region job keeps cpu running, stalling fetches served
// - stalling-region job halts cpu from start to completion
// - concurrent-region fetches invalid during any programming
// - boot loader section always lies inside stalling region
// - busy flag reads one while concurrent region blocked, save during stalling-region jobs
// - boot size fuses set application/boot boundary
// - two independent lock sets, one per section
// - application uses lock set 0, boot uses lock set 1
// - erase and write whole pages; fetches unaffected by paging
// - busy set on concurrent-region job start; region blocked
// - busy cleared by re-enable after completion or by page load
// - busy flag is bit 6, read only, resets zero
module fsp_ctrl
	import fsp_pkg::*;
#(
	parameter int unsigned PROG_CYC = FSP_PROG_CYC
) (
	input  wire logic                  pclk,      // system clock
	input  wire logic                  presetn,   // async reset, low
	input  wire logic                  ce,        // clock enable
	input  wire logic                  psel,      // apb select
	input  wire logic                  penable,   // apb enable
	input  wire logic                  pwrite,    // apb direction
	input  wire logic [31:0]           paddr,     // apb address
	input  wire logic [31:0]           pwdata,    // apb write data
	output logic      [31:0]           prdata,    // apb read data
	output logic                       pready,    // apb ready
	output logic                       pslverr,   // apb error
	input  wire fsp_pkg::fsp_store_s   store,     // store instruction
	input  wire fsp_pkg::fsp_fetch_s   fetch,     // code fetch / table read
	output logic                       fetch_ok,  // fetch data valid
	output logic                       cpu_stall, // halt processor
	output logic                       conc_blk,  // concurrent region block
	output logic                       flash_ers, // page erase strobe
	output logic                       flash_wrt, // page write strobe
	output logic [FSP_ADDR_W-1:0]      flash_pg   // page base address
);
	import fsp_pkg::*;

	fsp_state_e            st_r, st_nxt;
	logic [15:0]           cnt_r, cnt_nxt;
	logic                  busy_r, busy_nxt;
	logic                  done_r, done_nxt;
	logic [3:0]            lock_r, lock_nxt;
	logic [1:0]            fuse_r, fuse_nxt;
	logic [31:0]           prdata_nxt;
	logic                  pready_r, pready_nxt, pslverr_nxt;
	logic                  stall_nxt, blk_nxt, ok_nxt;
	logic                  ers_nxt, wrt_nxt;
	logic [FSP_ADDR_W-1:0] pg_nxt;
	logic                  stall_r, blk_r, ok_r, ers_r, wrt_r;
	logic [FSP_ADDR_W-1:0] pg_r;
	logic [31:0]           prdata_r;
	logic                  pslverr_r;
	logic                  pc_boot, z_boot, z_stall, f_stall;
	logic                  locked, go, acc, commit;

	fsp_section_map u_pc (
		.addr      (store.pc),
		.boot_size (fuse_r),
		.in_boot   (pc_boot),
		.in_stall  ()
	);
	fsp_section_map u_z (
		.addr      (store.zptr),
		.boot_size (fuse_r),
		.in_boot   (z_boot),
		.in_stall  (z_stall)
	);
	fsp_section_map u_f (
		.addr      (fetch.addr),
		.boot_size (fuse_r),
		.in_boot   (),
		.in_stall  (f_stall)
	);

	always_comb begin
		acc         = psel && penable && !pready_r;
		// writes land on the edge where the master sees pready high
		commit      = psel && penable && pwrite && pready_r;
		// lock bits are active low: a zero forbids stores into its section
		locked      = z_boot ? !lock_r[2] : !lock_r[0];
		go          = store.valid && (store.erase || store.write)
			&& pc_boot && !locked && (st_r == FSP_IDLE);
		st_nxt      = st_r;
		cnt_nxt     = cnt_r;
		busy_nxt    = busy_r;
		done_nxt    = done_r;
		lock_nxt    = lock_r;
		fuse_nxt    = fuse_r;
		ers_nxt     = 1'b0;
		wrt_nxt     = 1'b0;
		pg_nxt      = pg_r;
		prdata_nxt  = prdata_r;
		pready_nxt  = acc;
		pslverr_nxt = 1'b0;
		case (st_r)
			FSP_IDLE: begin
				if (go) begin
					ers_nxt = store.erase;
					wrt_nxt = store.write && !store.erase;
					pg_nxt  = {store.zptr[FSP_ADDR_W-1:FSP_PAGE_W],
						FSP_PAGE_W'(0)};
					cnt_nxt = 16'(PROG_CYC);
					done_nxt = 1'b0;
					if (z_stall) begin
						st_nxt = FSP_RUN_STALL;
					end else begin
						st_nxt   = FSP_RUN_CONC;
						busy_nxt = 1'b1;
					end
				end else if (store.valid && store.load && pc_boot) begin
					busy_nxt = 1'b0;
				end
			end
			FSP_RUN_CONC, FSP_RUN_STALL: begin
				cnt_nxt = cnt_r - 16'h0001;
				if (cnt_r == 16'h0001) begin
					st_nxt   = FSP_IDLE;
					done_nxt = 1'b1;
				end
			end
			default: st_nxt = FSP_IDLE;
		endcase
		if (acc) begin
			case (paddr)
				FSP_CTRL_ADDR: begin
					prdata_nxt = 32'h0;
				end
				FSP_STAT_ADDR: begin
					prdata_nxt = 32'(busy_r) << FSP_BUSY_BIT;
					prdata_nxt[0] = (st_r != FSP_IDLE);
				end
				FSP_LOCK_ADDR: begin
					prdata_nxt = {28'h0, lock_r};
				end
				FSP_FUSE_ADDR: begin
					prdata_nxt = {30'h0, fuse_r};
				end
				default: begin
					prdata_nxt  = 32'h0;
					pslverr_nxt = 1'b1;
				end
			endcase
		end
		if (commit) begin
			case (paddr)
				FSP_CTRL_ADDR: begin
					// a job starting now keeps the flag: set wins
					if (pwdata[FSP_REEN_BIT] && done_r
						&& st_nxt == FSP_IDLE && !go) begin
						busy_nxt = 1'b0;
					end
				end
				FSP_LOCK_ADDR: begin
					// bits only program to zero; erase is outside this block
					lock_nxt = lock_r & pwdata[3:0];
				end
				FSP_FUSE_ADDR: begin
					if (st_r == FSP_IDLE) begin
						fuse_nxt = pwdata[1:0];
					end
				end
				default: begin
					lock_nxt = lock_nxt;
				end
			endcase
		end
		stall_nxt = (st_nxt == FSP_RUN_STALL);
		blk_nxt   = busy_nxt || (st_nxt != FSP_IDLE);
		// fetches of the stalling region stay live under concurrent jobs
		ok_nxt    = fetch.valid && (f_stall ? (st_nxt != FSP_RUN_STALL)
			: !blk_nxt);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= FSP_IDLE;
			cnt_r     <= 16'h0;
			busy_r    <= 1'b0;
			done_r    <= 1'b0;
			lock_r    <= FSP_LOCK_RST;
			fuse_r    <= FSP_FUSE_RST;
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			stall_r   <= 1'b0;
			blk_r     <= 1'b0;
			ok_r      <= 1'b0;
			ers_r     <= 1'b0;
			wrt_r     <= 1'b0;
			pg_r      <= '0;
		end else if (ce) begin
			st_r      <= st_nxt;
			cnt_r     <= cnt_nxt;
			busy_r    <= busy_nxt;
			done_r    <= done_nxt;
			lock_r    <= lock_nxt;
			fuse_r    <= fuse_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			stall_r   <= stall_nxt;
			blk_r     <= blk_nxt;
			ok_r      <= ok_nxt;
			ers_r     <= ers_nxt;
			wrt_r     <= wrt_nxt;
			pg_r      <= pg_nxt;
		end
	end

	assign prdata    = prdata_r;
	assign pready    = pready_r;
	assign pslverr   = pslverr_r;
	assign cpu_stall = stall_r;
	assign conc_blk  = blk_r;
	assign fetch_ok  = ok_r;
	assign flash_ers = ers_r;
	assign flash_wrt = wrt_r;
	assign flash_pg  = pg_r;
endmodule : fsp_ctrl

// ### testbench/fsp_ctrl_chk.sv
`timescale 1ns/1ns
module fsp_ctrl_chk
	import fsp_pkg::*;
#(
	parameter int unsigned PROG_CYC = 4
) (
	input wire logic                  pclk,      // clock
	input wire logic                  presetn,   // reset
	input wire fsp_pkg::fsp_store_s   store,     // store
	input wire fsp_pkg::fsp_fetch_s   fetch,     // fetch
	input wire logic                  fetch_ok,  // fetch valid
	input wire logic                  cpu_stall, // stall
	input wire logic                  conc_blk,  // block
	input wire logic                  flash_ers, // erase
	input wire logic                  flash_wrt, // write
	input wire logic [FSP_ADDR_W-1:0] flash_pg   // page
);
	localparam int HOLD = PROG_CYC - 1;
	wire go = flash_ers | flash_wrt;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// below 0x3800 is application whatever the boot size
	AST_APP: assert property (store.valid && store.pc < 14'h3800 |=> !go)
		else $error("app store ran");
	AST_PAGE: assert property (go |-> flash_pg[5:0] == 6'h00 ##1 !go)
		else $error("bad page strobe");
	AST_MODE: assert property (go |-> conc_blk
		&& cpu_stall == (flash_pg >= 14'h3000)) else $error("wrong mode");
	AST_LEN: assert property ($rose(cpu_stall) |-> ##HOLD cpu_stall
		##1 !cpu_stall) else $error("stall length");
	AST_CAUSE: assert property ($rose(cpu_stall) |-> go)
		else $error("stray stall");
	AST_BLK: assert property (cpu_stall |-> conc_blk)
		else $error("stall unblocked");
	AST_CONC: assert property (fetch.valid && fetch.addr < 14'h3000
		|=> !(conc_blk && fetch_ok)) else $error("blocked code fetched");
	AST_SERVE: assert property (fetch.valid && fetch.addr >= 14'h3000
		|=> cpu_stall || fetch_ok) else $error("stall code refused");
	cover property (flash_ers && !cpu_stall);
	cover property (flash_wrt && cpu_stall);
	cover property ($fell(conc_blk) && !$past(cpu_stall));
endmodule : fsp_ctrl_chk

// ### testbench/fsp_cpu_model.sv
`timescale 1ns/1ns
module fsp_cpu_model
	import fsp_pkg::*;
(
	input  wire logic          pclk,     // clock
	input  wire logic          fetch_ok, // fetch valid
	output fsp_pkg::fsp_store_s store,    // store
	output fsp_pkg::fsp_fetch_s fetch     // fetch
);
	// no interrupt fetches at all, so none can land in blocked code
	initial store = '0;
	initial fetch = '0;
	// kind: erase, write, load from high bit down
	task automatic run_store(input logic [13:0] pc, zp, input logic [2:0] k);
		@(posedge pclk);
		store <= {1'b1, pc, zp, k};
		@(posedge pclk);
		store <= {1'b0, ~pc, ~zp, 3'h0};
	endtask : run_store
	// callers read blocked code only on purpose
	task automatic run_fetch(input logic [13:0] a, output logic ok);
		@(posedge pclk);
		fetch <= {1'b1, a};
		@(posedge pclk);
		fetch <= {1'b0, ~a};
		@(negedge pclk);
		ok = fetch_ok;
	endtask : run_fetch
endmodule : fsp_cpu_model

// ### testbench/test_flash_self_program_section_control.sv
`timescale 1ns/1ns
module test_flash_self_program_section_control;
	import fsp_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, fetch_ok, cpu_stall;
	logic        conc_blk, flash_ers, flash_wrt, ok, er;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic [13:0] flash_pg;
	fsp_store_s  store;
	fsp_fetch_s  fetch;
	int          failures = 0, total_checks = 0, cyc = 0, n_ers = 0, n_wrt = 0;
	always #10 pclk = ~pclk;
	always @(negedge pclk) begin
		n_ers += flash_ers;
		n_wrt += flash_wrt;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			print_verdict();
		end
	end
	fsp_ctrl #(.PROG_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.store(store), .fetch(fetch), .fetch_ok(fetch_ok),
		.cpu_stall(cpu_stall), .conc_blk(conc_blk), .flash_ers(flash_ers),
		.flash_wrt(flash_wrt), .flash_pg(flash_pg));
	fsp_cpu_model cpu (.pclk(pclk), .fetch_ok(fetch_ok), .store(store),
		.fetch(fetch));
	task automatic chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// request holds until the rising edge that samples pready high
	task automatic apb(input logic wr, input logic [31:0] a, d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic fx(input logic [13:0] a, input logic exp);
		cpu.run_fetch(a, ok);
		chk(ok, exp);
	endtask : fx
	task automatic print_verdict();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, FSP_STAT_ADDR, 0);
		chk(rd, 0);
		apb(0, FSP_LOCK_ADDR, 0);
		chk(rd, FSP_LOCK_RST);
		apb(0, 32'h0000_0010, 0);
		chk(rd + er, 1);
		cpu.run_store(14'h3810, 14'h0085, 3'h4);
		apb(0, FSP_STAT_ADDR, 0);
		chk(rd + n_ers, 0);
		apb(1, FSP_FUSE_ADDR, 3);
		cpu.run_store(14'h3810, 14'h0085, 3'h4);
		@(negedge pclk);
		chk({flash_ers, cpu_stall, conc_blk}, 3'h5);
		chk(flash_pg, 14'h0080);
		fx(14'h3000, 1);
		fx(14'h0010, 0);
		repeat (6) @(posedge pclk);
		apb(0, FSP_STAT_ADDR, 0);
		chk(rd, 32'h40);
		fx(14'h0010, 0);
		apb(1, FSP_CTRL_ADDR, 32'h10);
		apb(0, FSP_STAT_ADDR, 0);
		chk(rd, 0);
		fx(14'h0010, 1);
		cpu.run_store(14'h3F10, 14'h3F45, 3'h2);
		@(negedge pclk);
		chk({flash_wrt, cpu_stall, flash_pg}, {2'h3, 14'h3F40});
		repeat (4) @(negedge pclk);
		chk({cpu_stall, conc_blk}, 0);
		cpu.run_store(14'h3F10, 14'h0100, 3'h2);
		repeat (6) @(posedge pclk);
		cpu.run_store(14'h3F10, 14'h0000, 3'h1);
		apb(0, FSP_STAT_ADDR, 0);
		chk(rd + n_wrt, 2);
		apb(1, FSP_LOCK_ADDR, 32'hE);
		apb(1, FSP_LOCK_ADDR, 32'hF);
		apb(0, FSP_LOCK_ADDR, 0);
		chk(rd, 32'hE);
		cpu.run_store(14'h3F10, 14'h3F00, 3'h4);
		repeat (6) @(posedge pclk);
		cpu.run_store(14'h3F10, 14'h0040, 3'h4);
		repeat (2) @(negedge pclk);
		chk(n_ers, 2);
		print_verdict();
	end
endmodule : test_flash_self_program_section_control
bind fsp_ctrl fsp_ctrl_chk #(.PROG_CYC(PROG_CYC)) u_chk (.pclk(pclk),
	.presetn(presetn), .store(store), .fetch(fetch), .fetch_ok(fetch_ok),
	.cpu_stall(cpu_stall), .conc_blk(conc_blk), .flash_ers(flash_ers),
	.flash_wrt(flash_wrt), .flash_pg(flash_pg));
